// [rtl/itb_pkg.sv]
package itb_pkg;
  localparam int IPR_AW = 32;
  localparam int IPR_DW = 32;
  localparam int RSP_W = 64;
  localparam int WQ_DEPTH = 8;
  // Register offsets
  localparam logic [IPR_AW-1:0] ADR_CTRL = 32'h00000018;
  localparam logic [IPR_AW-1:0] ADR_RELOAD = 32'h00000019;
  localparam logic [IPR_AW-1:0] ADR_COUNT = 32'h0000001a;
  // Address block owned by this unit
  localparam logic [IPR_AW-1:0] BLK_LO = 32'h00000018;
  localparam logic [IPR_AW-1:0] BLK_HI = 32'h000000b0;
  // Control/status fields
  localparam int BIT_MISSED = 31;
  localparam int BIT_PEND = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_SGL = 5;
  localparam int BIT_XFR = 4;
  localparam int BIT_RUN = 0;
  // Reset values
  localparam logic [IPR_DW-1:0] RST_COUNT = 32'h00000000;
  localparam logic [IPR_DW-1:0] RST_RELOAD = 32'h00000000;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0]
  {
    ITB_RD_IDLE = 3'b001,
    ITB_RD_DRAIN = 3'b010,
    ITB_RD_ANSWER = 3'b100
  } itb_rd_state_e;
endpackage : itb_pkg

// [rtl/itb_top.sv]
// Operation
// - Register reads and writes complete only after the write queue ahead of them drains.
// - A register read marks every valid queued write as conflicting before being served.
// - A register write joins the write queue behind all earlier writes.
// - A read of this unit's registers returns one quadword, not four.
// - Reading write-only or unimplemented registers returns unspecified data.
// - Writes to unimplemented registers inside the block are dropped silently.
// - Writes outside the block are dropped; reads there return unspecified data.
// - Control/status at 18, write-only reload at 19, read-only count at 1A.
// - Overflow while pending flag set raises missed flag, bit 31, write-one clear.
// - Every overflow sets pending flag, bit 7, write-one clear; posts interrupt if enabled.
// - Reset clears interrupt enable and run.
// - Interrupt enable, bit 6; enabling while pending raises interrupt at once.
// - Single-step bit 5 adds one per write when run clear and transfer not written.
// - Transfer bit 4 copies reload into count once per write; reads zero.
// - With run bit 0 set the count advances once per microsecond.
// - Reload value is kept after loading and reset clears it.
// - On carry-out the count reloads and keeps counting; reset clears the count.
`timescale 1ns/1ns
module itb_top #(parameter int WQ_DEPTH_P = itb_pkg::WQ_DEPTH, parameter int TICK_P = itb_pkg::TICK_CYCLES)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_IPR,
  input wire logic CMD_WRITE,
  input wire logic [itb_pkg::IPR_AW-1:0] CMD_ADDR,
  input wire logic [itb_pkg::IPR_DW-1:0] CMD_WDATA,
  output logic RSP_VALID,
  output logic [itb_pkg::RSP_W-1:0] RSP_DATA,
  output logic WQ_OUT_VALID,
  input wire logic WQ_OUT_READY,
  output logic [itb_pkg::IPR_AW-1:0] WQ_OUT_ADDR,
  output logic [itb_pkg::IPR_DW-1:0] WQ_OUT_DATA,
  output logic TIMER_IRQ
);
  import itb_pkg::*;

  itb_wq_if #(.AW(IPR_AW), .DW(IPR_DW)) wq ();

  itb_write_queue #(.DEPTH(WQ_DEPTH_P), .AW(IPR_AW), .DW(IPR_DW)) u_queue
  (
    .clk(CLK),
    .rst(RST),
    .wq(wq)
  );

  logic tick;

  itb_us_tick #(.CYCLES(TICK_P)) u_tick
  (
    .clk(CLK),
    .rst(RST),
    .tick(tick)
  );

  itb_rd_state_e state_reg, state_next;
  logic ready_reg;
  logic rsp_valid_reg;
  logic [RSP_W-1:0] rsp_data_reg;
  logic [IPR_AW-1:0] rd_addr_reg;
  logic [IPR_DW-1:0] count_reg, count_next;
  logic [IPR_DW-1:0] reload_reg, reload_next;
  logic missed_reg, missed_next;
  logic pend_reg, pend_next;
  logic ie_reg, ie_next;
  logic run_reg, run_next;
  logic irq_reg;

  // Command intake
  wire take = CMD_VALID & ready_reg;
  wire take_wr = take & CMD_WRITE;
  wire take_rd = take & ~CMD_WRITE;
  assign wq.push_valid = take_wr;
  assign wq.push_ipr = CMD_IPR;
  assign wq.push_addr = CMD_ADDR;
  assign wq.push_data = CMD_WDATA;
  assign wq.mark_all = take_rd;

  // Queue head: external writes leave by the port, register writes are applied here
  wire apply_wr = wq.head_valid & wq.head_ipr;
  assign wq.pop = apply_wr | (wq.head_ext & WQ_OUT_READY);
  wire [IPR_DW-1:0] wd = wq.head_data;
  wire ctrl_wr = apply_wr & (wq.head_addr == ADR_CTRL);
  wire reload_wr = apply_wr & (wq.head_addr == ADR_RELOAD);
  // Count is read-only and any other address is ignored on write
  wire dropped_wr = apply_wr & ~ctrl_wr & ~reload_wr;

  // Timer events
  wire reload_transfer_pulse = ctrl_wr & wd[BIT_XFR];
  wire single_step_pulse = ctrl_wr & wd[BIT_SGL] & ~wd[BIT_XFR] & ~run_reg;
  wire inc = ~reload_transfer_pulse & (single_step_pulse | (run_reg & tick));
  wire at_top = (count_reg == '1);
  wire ovf = inc & at_top;
  wire clr_pend = ctrl_wr & wd[BIT_PEND];
  wire clr_missed = ctrl_wr & wd[BIT_MISSED];

  always_comb
  begin
    count_next = count_reg;
    if (reload_transfer_pulse || ovf)
    begin
      count_next = reload_reg;
    end
    else if (inc)
    begin
      count_next = count_reg + 32'h00000001;
    end
  end

  // The reload register is only ever changed by its own write
  assign reload_next = reload_wr ? wd : reload_reg;
  // Hardware set wins over a write-one clear in the same cycle
  assign pend_next = ovf | (pend_reg & ~clr_pend);
  assign missed_next = (ovf & pend_reg) | (missed_reg & ~clr_missed);
  assign ie_next = ctrl_wr ? wd[BIT_IE] : ie_reg;
  assign run_next = ctrl_wr ? wd[BIT_RUN] : run_reg;

  // Read answer; reserved and pulse bits read zero
  wire [IPR_DW-1:0] ctrl_view = {missed_reg, 23'h000000, pend_reg, ie_reg, 5'h00, run_reg};
  wire rd_ctrl = (rd_addr_reg == ADR_CTRL);
  wire rd_count = (rd_addr_reg == ADR_COUNT);
  // Reload, unimplemented and foreign addresses all answer zero
  wire [IPR_DW-1:0] rd_word = rd_ctrl ? ctrl_view : (rd_count ? count_reg : '0);
  wire drain_done = (state_reg == ITB_RD_DRAIN) & ~wq.any_conflict;

  always_comb
  begin
    unique case (state_reg)
      ITB_RD_IDLE:
        state_next = take_rd ? ITB_RD_DRAIN : ITB_RD_IDLE;
      ITB_RD_DRAIN:
        state_next = drain_done ? ITB_RD_ANSWER : ITB_RD_DRAIN;
      ITB_RD_ANSWER:
        state_next = ITB_RD_IDLE;
      default:
        state_next = ITB_RD_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ITB_RD_IDLE;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      rd_addr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= (state_next == ITB_RD_IDLE) & ~wq.full_next;
      rsp_valid_reg <= drain_done;
      rsp_data_reg <= drain_done ? {32'h00000000, rd_word} : '0;
      rd_addr_reg <= take_rd ? CMD_ADDR : rd_addr_reg;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      count_reg <= RST_COUNT;
      reload_reg <= RST_RELOAD;
      missed_reg <= 1'b0;
      pend_reg <= 1'b0;
      ie_reg <= 1'b0;
      run_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      reload_reg <= reload_next;
      missed_reg <= missed_next;
      pend_reg <= pend_next;
      ie_reg <= ie_next;
      run_reg <= run_next;
      irq_reg <= pend_next & ie_next;
    end
  end

  assign CMD_READY = ready_reg;
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_DATA = rsp_data_reg;
  assign WQ_OUT_VALID = wq.head_ext;
  assign WQ_OUT_ADDR = wq.head_addr;
  assign WQ_OUT_DATA = wq.head_data;
  assign TIMER_IRQ = irq_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  AST_ANSWER_AFTER_DRAIN: assert property (rsp_valid_reg |-> $past(~wq.any_conflict))
    else $error("Read answered while marked writes remained");
  AST_READ_MARKS_QUEUE: assert property (take_rd && wq.head_valid && !wq.pop |=> wq.any_conflict)
    else $error("Queued write not marked by read");
  AST_WRITE_QUEUED: assert property (take_wr |=> wq.head_valid)
    else $error("Write did not enter the queue");
  AST_SINGLE_BEAT: assert property (rsp_valid_reg |=> !rsp_valid_reg)
    else $error("Read answer longer than one beat");
  AST_RELOAD_READS_ZERO: assert property (drain_done && rd_addr_reg == ADR_RELOAD |=> RSP_DATA == '0)
    else $error("Reload read returned stored value");
  AST_DROP_KEEPS_STATE: assert property (dropped_wr && !tick |=> $stable(count_reg) && $stable(reload_reg))
    else $error("Dropped write changed timer");
  AST_MISSED_SET: assert property (ovf && pend_reg |=> missed_reg && pend_reg)
    else $error("Missed flag not set on second overflow");
  AST_OVF_PEND_IRQ: assert property (ovf && ie_next |=> pend_reg ##0 TIMER_IRQ)
    else $error("Overflow did not raise flag and interrupt");
  AST_IE_LATE: assert property (pend_reg && !ie_reg && ctrl_wr && wd[BIT_IE] && !clr_pend |=> TIMER_IRQ)
    else $error("Enabling with flag pending did not interrupt");
  AST_STEP: assert property (single_step_pulse && !at_top |=> count_reg == $past(count_reg) + 32'h00000001)
    else $error("Single step did not add one");
  AST_XFR: assert property (reload_transfer_pulse |=> count_reg == $past(reload_reg))
    else $error("Transfer did not load count");
  AST_RUN_TICK: assert property (run_reg && tick && !apply_wr && !at_top |=> count_reg == $past(count_reg) + 32'h00000001)
    else $error("Running count missed a tick");
  AST_WRAP: assert property (ovf && !reload_wr |=> count_reg == $past(reload_reg) && reload_reg == $past(reload_reg))
    else $error("Overflow did not reload");
  AST_IRQ_LEVEL: assert property (TIMER_IRQ == $past(pend_next & ie_next))
    else $error("Interrupt not following flag and enable");
endmodule : itb_top

// [rtl/itb_us_tick.sv]
`timescale 1ns/1ns
module itb_us_tick #(parameter int CYCLES = 125)
(
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  logic [CW-1:0] div_reg;
  wire wrap = (div_reg == CW'(CYCLES - 1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div_reg <= wrap ? '0 : div_reg + CW'(1);
      tick <= wrap;
    end
  end
endmodule : itb_us_tick

// [rtl/itb_wq_if.sv]
`timescale 1ns/1ns
interface itb_wq_if #(parameter int AW = 32, parameter int DW = 32);
  logic push_valid;
  logic push_ipr;
  logic [AW-1:0] push_addr;
  logic [DW-1:0] push_data;
  logic full_next;
  logic head_valid;
  logic head_ipr;
  logic head_ext;
  logic [AW-1:0] head_addr;
  logic [DW-1:0] head_data;
  logic pop;
  logic mark_all;
  logic any_conflict;
  modport owner
  (
    output push_valid, push_ipr, push_addr, push_data, pop, mark_all,
    input full_next, head_valid, head_ipr, head_ext, head_addr, head_data, any_conflict
  );
  modport queue
  (
    input push_valid, push_ipr, push_addr, push_data, pop, mark_all,
    output full_next, head_valid, head_ipr, head_ext, head_addr, head_data, any_conflict
  );
endinterface : itb_wq_if

// [rtl/itb_write_queue.sv]
`timescale 1ns/1ns
// Shift queue: the head always sits in slot 0, so its outputs are plain flops
module itb_write_queue #(parameter int DEPTH = 8, parameter int AW = 32, parameter int DW = 32)
(
  input wire logic clk,
  input wire logic rst,
  itb_wq_if.queue wq
);
  import itb_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  logic [DEPTH-1:0] valid_reg, ipr_reg, ext_reg, conf_reg;
  logic [DEPTH-1:0] valid_next, ipr_next, ext_next, conf_next;
  logic [AW-1:0] addr_reg [DEPTH];
  logic [AW-1:0] addr_next [DEPTH];
  logic [DW-1:0] data_reg [DEPTH];
  logic [DW-1:0] data_next [DEPTH];
  logic [CW-1:0] count_reg, count_next, slot;
  wire do_pop = wq.pop & valid_reg[0];
  always_comb
  begin
    slot = count_reg - CW'(do_pop);
    for (int i = 0; i < DEPTH; i++)
    begin
      if (do_pop && i < DEPTH - 1)
      begin
        valid_next[i] = valid_reg[i+1];
        ipr_next[i] = ipr_reg[i+1];
        ext_next[i] = ext_reg[i+1];
        conf_next[i] = conf_reg[i+1];
        addr_next[i] = addr_reg[i+1];
        data_next[i] = data_reg[i+1];
      end
      else
      begin
        valid_next[i] = do_pop ? 1'b0 : valid_reg[i];
        ipr_next[i] = do_pop ? 1'b0 : ipr_reg[i];
        ext_next[i] = do_pop ? 1'b0 : ext_reg[i];
        conf_next[i] = do_pop ? 1'b0 : conf_reg[i];
        addr_next[i] = addr_reg[i];
        data_next[i] = data_reg[i];
      end
      // Every entry already queued is marked ahead of the read
      conf_next[i] = conf_next[i] | (wq.mark_all & valid_next[i]);
      if (wq.push_valid && slot == CW'(i))
      begin
        valid_next[i] = 1'b1;
        ipr_next[i] = wq.push_ipr;
        ext_next[i] = ~wq.push_ipr;
        conf_next[i] = 1'b0;
        addr_next[i] = wq.push_addr;
        data_next[i] = wq.push_data;
      end
    end
    count_next = slot + CW'(wq.push_valid);
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valid_reg <= '0;
      ipr_reg <= '0;
      ext_reg <= '0;
      conf_reg <= '0;
      count_reg <= '0;
      addr_reg <= '{default: '0};
      data_reg <= '{default: '0};
    end
    else
    begin
      valid_reg <= valid_next;
      ipr_reg <= ipr_next;
      ext_reg <= ext_next;
      conf_reg <= conf_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end
  assign wq.full_next = (count_next == CW'(DEPTH));
  assign wq.head_valid = valid_reg[0];
  assign wq.head_ipr = ipr_reg[0];
  assign wq.head_ext = ext_reg[0];
  assign wq.head_addr = addr_reg[0];
  assign wq.head_data = data_reg[0];
  assign wq.any_conflict = |conf_reg;
endmodule : itb_write_queue

// [verification/itb_mmu_model.sv]
`timescale 1ns/1ns
module itb_mmu_model
(
  input wire logic CLK,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  input wire logic [itb_pkg::RSP_W-1:0] RSP_DATA,
  output logic CMD_VALID,
  output logic CMD_IPR,
  output logic CMD_WRITE,
  output logic [itb_pkg::IPR_AW-1:0] CMD_ADDR,
  output logic [itb_pkg::IPR_DW-1:0] CMD_WDATA
);
  import itb_pkg::*;
  initial
  begin
    CMD_VALID = 1'b0;
    CMD_IPR = 1'b0;
    CMD_WRITE = 1'b0;
    CMD_ADDR = 32'h0;
    CMD_WDATA = 32'h0;
  end
  // Released address and data lines show the inverse so a stale value never passes for a live one
  // No wait limit here: a stuck handshake is left to the bench watchdog, which counts it as a mismatch
  task automatic req(input logic w, input logic internal_processor_register, input logic [IPR_AW-1:0] a, input logic [IPR_DW-1:0] d);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_IPR = internal_processor_register;
    CMD_WRITE = w;
    CMD_ADDR = a;
    CMD_WDATA = d;
    while (CMD_READY !== 1'b1)
    begin
      @(negedge CLK);
    end
    @(posedge CLK);
    @(negedge CLK);
    CMD_VALID = 1'b0;
    CMD_ADDR = ~a;
    CMD_WDATA = ~d;
  endtask : req
  task automatic rd(input logic [IPR_AW-1:0] a, output logic [RSP_W-1:0] q);
    req(1'b0, 1'b1, a, 32'h0);
    while (RSP_VALID !== 1'b1)
    begin
      @(negedge CLK);
    end
    q = RSP_DATA;
  endtask : rd
endmodule : itb_mmu_model

// [verification/itb_top_test.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module itb_top_test;
  import itb_pkg::*;
  localparam int TK = 4;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic sink_rdy = 1'b1;
  logic cmd_valid, cmd_ready, cmd_ipr, cmd_write, rsp_valid, wq_valid, irq, seen;
  logic [IPR_AW-1:0] cmd_addr, wq_addr;
  logic [IPR_DW-1:0] cmd_wdata, wq_data;
  logic [RSP_W-1:0] rsp_data, q, prev;
  int err_count = 0;
  int n_tests = 0;
  itb_top #(.WQ_DEPTH_P(WQ_DEPTH), .TICK_P(TK)) uut (.CLK(CLK), .RST(RST), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_IPR(cmd_ipr), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .WQ_OUT_VALID(wq_valid),
    .WQ_OUT_READY(sink_rdy), .WQ_OUT_ADDR(wq_addr), .WQ_OUT_DATA(wq_data), .TIMER_IRQ(irq));
  itb_mmu_model m (.CLK(CLK), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .CMD_VALID(cmd_valid), .CMD_IPR(cmd_ipr), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata));
  initial forever #4 CLK = ~CLK;
  task automatic wr(input logic [IPR_AW-1:0] a, input logic [IPR_DW-1:0] d);
    m.req(1'b1, 1'b1, a, d);
  endtask : wr
  // Full quadword compare, so the upper half must come back zero
  task automatic rc(input logic [IPR_AW-1:0] a, input logic [RSP_W-1:0] e);
    m.rd(a, q);
    `CHK(q, e)
  endtask : rc
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic t_basic;
    rc(ADR_CTRL, 64'h0);
    rc(ADR_COUNT, 64'h0);
    wr(ADR_RELOAD, 32'h12345678);
    rc(ADR_RELOAD, 64'h0);
    wr(ADR_CTRL, 32'h10);
    rc(ADR_COUNT, 64'h12345678);
    wr(ADR_CTRL, 32'h20);
    wr(ADR_CTRL, 32'h20);
    rc(ADR_COUNT, 64'h1234567a);
    rc(ADR_CTRL, 64'h0);
    wr(ADR_CTRL, 32'h30);
    rc(ADR_COUNT, 64'h12345678);
    wr(ADR_COUNT, 32'h5);
    wr(32'h1c, 32'h5);
    wr(32'h200, 32'h5);
    rc(ADR_COUNT, 64'h12345678);
    rc(32'h200, 64'h0);
    rc(32'h1c, 64'h0);
  endtask : t_basic
  task automatic t_ovf;
    wr(ADR_RELOAD, 32'hfffffffe);
    wr(ADR_CTRL, 32'h10);
    wr(ADR_CTRL, 32'h20);
    rc(ADR_COUNT, 64'hffffffff);
    wr(ADR_CTRL, 32'h20);
    rc(ADR_COUNT, 64'hfffffffe);
    rc(ADR_CTRL, 64'h80);
    `CHK(irq, 1'b0)
    wr(ADR_CTRL, 32'h40);
    rc(ADR_CTRL, 64'hc0);
    `CHK(irq, 1'b1)
    wr(ADR_CTRL, 32'h60);
    wr(ADR_CTRL, 32'h60);
    rc(ADR_CTRL, 64'h800000c0);
    wr(ADR_CTRL, 32'hc0);
    rc(ADR_CTRL, 64'h80000040);
    `CHK(irq, 1'b0)
    wr(ADR_CTRL, 32'h80000040);
    rc(ADR_CTRL, 64'h40);
  endtask : t_ovf
  // A 44-cycle run window holds 11 ticks; a step honoured while running gives 12
  task automatic t_run;
    wr(ADR_RELOAD, 32'h0);
    wr(ADR_CTRL, 32'h10);
    wr(ADR_CTRL, 32'h1);
    wr(ADR_CTRL, 32'h21);
    repeat (40) @(negedge CLK);
    wr(ADR_CTRL, 32'h0);
    m.rd(ADR_COUNT, prev);
    `CHK((prev >= 10 && prev <= 11), 1'b1)
    repeat (20) @(negedge CLK);
    rc(ADR_COUNT, prev);
  endtask : t_run
  task automatic t_order;
    sink_rdy = 1'b0;
    seen = 1'b0;
    m.req(1'b1, 1'b0, 32'h1000, 32'hcafe);
    wr(ADR_CTRL, 32'h20);
    fork
      m.rd(ADR_COUNT, q);
      begin
        repeat (12)
        begin
          @(negedge CLK);
          seen = seen | rsp_valid;
        end
        `CHK(seen, 1'b0)
        `CHK({wq_valid, wq_addr, wq_data}, {1'b1, 32'h1000, 32'hcafe})
        sink_rdy = 1'b1;
      end
    join
    `CHK(q, prev + 1)
    `CHK(wq_valid, 1'b0)
  endtask : t_order
  initial
  begin
    repeat (20) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    repeat (3) @(negedge CLK);
    t_basic();
    t_ovf();
    t_run();
    t_order();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge CLK);
    err_count++;
    wrap_up();
  end
endmodule : itb_top_test
